// ==== verilog/bdp_brake_ctrl.sv ====
/*
  Brake sequencing and deceleration overvoltage protection of a motor drive,
  with its register file on a plain strobe port.
  Assumes run, direction, overvoltage and current inputs come from outside
  the ref_clk domain; the current word is slow enough to sample plainly.
*/
`timescale 1ns/1ps
module bdp_brake_ctrl
  import bdp_pkg::*;
#(
  parameter int TICK_CYCLES = BDP_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic forward_run_command,
  input wire logic reverse_select,
  input wire logic dc_bus_over,
  input wire logic [BDP_CUR_W-1:0] motor_current,
  output logic [BDP_FREQ_W-1:0] out_freq,
  output logic brake_release,
  output logic stall_active,
  output logic power_brake_active,
  output logic decel_vlimit_en,
  output logic dc_brake_on,
  output logic [7:0] dc_brake_level_out,
  output logic output_block
);

  typedef struct packed {
    logic [1:0] stop_method_select;
    logic [2:0] stall_guard_select;
    logic decel_voltage_limit_select;
    logic [1:0] control_method_select;
    logic [4:0] relay_function_select;
    logic [BDP_CUR_W-1:0] release_current_level;
    logic [BDP_DLY_W-1:0] release_hold_delay;
    logic [BDP_FREQ_W-1:0] forward_release_frequency;
    logic [BDP_FREQ_W-1:0] reverse_release_frequency;
    logic [BDP_DLY_W-1:0] engage_hold_delay;
    logic [BDP_FREQ_W-1:0] engage_frequency;
    logic [BDP_DLY_W-1:0] dc_brake_duration;
    logic [7:0] dc_brake_level;
    logic [BDP_FREQ_W-1:0] target_freq;
    logic [BDP_FREQ_W-1:0] ramp_step;
    bdp_state_t st;
    logic [BDP_FREQ_W-1:0] freq;
    logic rev;
    logic brake;
    logic stall;
    logic pbrake;
    logic [31:0] rdata;
    logic run_s1;
    logic run_s2;
    logic rev_s1;
    logic rev_s2;
    logic ov_s1;
    logic ov_s2;
    logic [BDP_CUR_W-1:0] cur_s1;
    logic [BDP_CUR_W-1:0] cur_s2;
  } bdp_state_reg_t;

  bdp_state_reg_t s_r;
  bdp_state_reg_t s_nxt;
  bdp_tmr_if tif ();

  bdp_hold_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .ref_clk(ref_clk),
    .srst(srst),
    .tif(tif)
  );

  // step up toward lim without overshoot; caller guarantees f <= lim
  function automatic logic [BDP_FREQ_W-1:0] ramp_up(
    input logic [BDP_FREQ_W-1:0] f,
    input logic [BDP_FREQ_W-1:0] stp,
    input logic [BDP_FREQ_W-1:0] lim
  );
    if ((lim - f) <= stp) begin
      return lim;
    end
    return f + stp;
  endfunction : ramp_up

  // step down toward lim without undershoot; caller guarantees f >= lim
  function automatic logic [BDP_FREQ_W-1:0] ramp_dn(
    input logic [BDP_FREQ_W-1:0] f,
    input logic [BDP_FREQ_W-1:0] stp,
    input logic [BDP_FREQ_W-1:0] lim
  );
    if ((f - lim) <= stp) begin
      return lim;
    end
    return f - stp;
  endfunction : ramp_dn

  logic pb_en;
  logic bseq_en;
  logic dvl_vis;
  logic acc_ph;
  logic con_ph;
  logic dec_ph;
  logic stall_on;
  logic pb_on;
  logic hold_ramp;
  logic reaccel;
  logic dcb_cfg;
  logic [BDP_FREQ_W-1:0] rel_f;
  logic [BDP_FREQ_W-1:0] floor_f;

  always_comb begin
    pb_en = (s_r.stop_method_select == BDP_STOP_POWER_BRAKE);
    bseq_en = (s_r.relay_function_select == BDP_RELAY_BRAKE);
    dvl_vis = s_r.decel_voltage_limit_select
      & s_r.stall_guard_select[BDP_STALL_DEC_BIT];
    rel_f = s_r.rev ? s_r.reverse_release_frequency
      : s_r.forward_release_frequency;
    floor_f = bseq_en ? s_r.engage_frequency : '0;
    dcb_cfg = (s_r.dc_brake_duration != '0) && (s_r.dc_brake_level != '0);
    acc_ph = (s_r.st == BDP_ST_TO_REL)
      || (s_r.st == BDP_ST_RUN && s_r.freq < s_r.target_freq);
    con_ph = (s_r.st == BDP_ST_RUN && s_r.freq == s_r.target_freq);
    dec_ph = (s_r.st == BDP_ST_DECEL)
      || (s_r.st == BDP_ST_RUN && s_r.freq > s_r.target_freq);
    stall_on = (acc_ph & s_r.stall_guard_select[BDP_STALL_ACC_BIT])
      | (con_ph & s_r.stall_guard_select[BDP_STALL_CON_BIT])
      | (dec_ph & s_r.stall_guard_select[BDP_STALL_DEC_BIT] & ~pb_en);
    pb_on = dec_ph & pb_en;
    // pausing the ramp lowers the effective slope while the bus is high
    hold_ramp = s_r.ov_s2 & stall_on;
    // power braking lifts the frequency only while it is below target_freq, so the motor stops regenerating
    reaccel = s_r.ov_s2 & pb_on & (s_r.freq < s_r.target_freq);
  end

  always_comb begin
    s_nxt = s_r;
    tif.load = 1'b0;
    tif.load_val = '0;

    s_nxt.run_s1 = forward_run_command;
    s_nxt.run_s2 = s_r.run_s1;
    s_nxt.rev_s1 = reverse_select;
    s_nxt.rev_s2 = s_r.rev_s1;
    s_nxt.ov_s1 = dc_bus_over;
    s_nxt.ov_s2 = s_r.ov_s1;
    s_nxt.cur_s1 = motor_current;
    s_nxt.cur_s2 = s_r.cur_s1;
    s_nxt.stall = hold_ramp;
    s_nxt.pbrake = s_r.ov_s2 & pb_on;

    s_nxt.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == BDP_A_CFG) begin
        s_nxt.rdata = {24'h000000, s_r.control_method_select, dvl_vis,
          s_r.stall_guard_select, s_r.stop_method_select};
      end else if (reg_addr == BDP_A_RELAY) begin
        s_nxt.rdata = {27'h0000000, s_r.relay_function_select};
      end else if (bseq_en && reg_addr == BDP_A_REL_CUR) begin
        s_nxt.rdata = {21'h000000, s_r.release_current_level};
      end else if (bseq_en && reg_addr == BDP_A_REL_DLY) begin
        s_nxt.rdata = {22'h000000, s_r.release_hold_delay};
      end else if (bseq_en && reg_addr == BDP_A_FWD_F) begin
        s_nxt.rdata = {16'h0000, s_r.forward_release_frequency};
      end else if (bseq_en && reg_addr == BDP_A_REV_F) begin
        s_nxt.rdata = {16'h0000, s_r.reverse_release_frequency};
      end else if (bseq_en && reg_addr == BDP_A_ENG_DLY) begin
        s_nxt.rdata = {22'h000000, s_r.engage_hold_delay};
      end else if (bseq_en && reg_addr == BDP_A_ENG_F) begin
        s_nxt.rdata = {16'h0000, s_r.engage_frequency};
      end else if (reg_addr == BDP_A_DCB_DUR) begin
        s_nxt.rdata = {22'h000000, s_r.dc_brake_duration};
      end else if (reg_addr == BDP_A_DCB_LVL) begin
        s_nxt.rdata = {24'h000000, s_r.dc_brake_level};
      end else if (reg_addr == BDP_A_TGT_F) begin
        s_nxt.rdata = {16'h0000, s_r.target_freq};
      end else if (reg_addr == BDP_A_STEP) begin
        s_nxt.rdata = {16'h0000, s_r.ramp_step};
      end else if (reg_addr == BDP_A_STATUS) begin
        s_nxt.rdata = {20'h00000, s_r.st, s_r.rev, s_r.ov_s2, s_r.pbrake,
          s_r.stall, bseq_en, pb_en, dvl_vis, s_r.brake};
      end else if (reg_addr == BDP_A_FREQ) begin
        s_nxt.rdata = {16'h0000, s_r.freq};
      end
    end

    if (reg_wr) begin
      if (reg_addr == BDP_A_CFG) begin
        s_nxt.stop_method_select = reg_wdata[BDP_CFG_STOP_LSB +: 2];
        s_nxt.stall_guard_select = reg_wdata[BDP_CFG_STALL_LSB +: 3];
        s_nxt.decel_voltage_limit_select = reg_wdata[BDP_CFG_DVL_BIT];
        s_nxt.control_method_select = reg_wdata[BDP_CFG_CTL_LSB +: 2];
      end else if (reg_addr == BDP_A_RELAY) begin
        s_nxt.relay_function_select = reg_wdata[4:0];
      end else if (bseq_en && reg_addr == BDP_A_REL_CUR) begin
        s_nxt.release_current_level = reg_wdata[BDP_CUR_W-1:0];
      end else if (bseq_en && reg_addr == BDP_A_REL_DLY) begin
        s_nxt.release_hold_delay = reg_wdata[BDP_DLY_W-1:0];
      end else if (bseq_en && reg_addr == BDP_A_FWD_F) begin
        s_nxt.forward_release_frequency = reg_wdata[BDP_FREQ_W-1:0];
      end else if (bseq_en && reg_addr == BDP_A_REV_F) begin
        s_nxt.reverse_release_frequency = reg_wdata[BDP_FREQ_W-1:0];
      end else if (bseq_en && reg_addr == BDP_A_ENG_DLY) begin
        s_nxt.engage_hold_delay = reg_wdata[BDP_DLY_W-1:0];
      end else if (bseq_en && reg_addr == BDP_A_ENG_F) begin
        s_nxt.engage_frequency = reg_wdata[BDP_FREQ_W-1:0];
      end else if (reg_addr == BDP_A_DCB_DUR) begin
        s_nxt.dc_brake_duration = reg_wdata[BDP_DLY_W-1:0];
      end else if (reg_addr == BDP_A_DCB_LVL) begin
        s_nxt.dc_brake_level = reg_wdata[7:0];
      end else if (reg_addr == BDP_A_TGT_F) begin
        s_nxt.target_freq = reg_wdata[BDP_FREQ_W-1:0];
      end else if (reg_addr == BDP_A_STEP) begin
        s_nxt.ramp_step = reg_wdata[BDP_FREQ_W-1:0];
      end
    end

    case (s_r.st)
      BDP_ST_IDLE: begin
        s_nxt.freq = '0;
        s_nxt.brake = 1'b0;
        if (s_r.run_s2) begin
          s_nxt.rev = s_r.rev_s2;
          // brake sequencing assumes plain V/f control was chosen by software
          s_nxt.st = bseq_en ? BDP_ST_TO_REL : BDP_ST_RUN;
        end
      end
      BDP_ST_TO_REL: begin
        if (!s_r.run_s2) begin
          s_nxt.st = BDP_ST_DECEL;
        end else if (s_r.freq >= rel_f) begin
          s_nxt.freq = rel_f;
          s_nxt.st = BDP_ST_WAIT_CUR;
        end else if (tif.tick && !hold_ramp) begin
          s_nxt.freq = ramp_up(s_r.freq, s_r.ramp_step, rel_f);
        end
      end
      BDP_ST_WAIT_CUR: begin
        if (!s_r.run_s2) begin
          s_nxt.st = BDP_ST_DECEL;
        end else if (s_r.cur_s2 >= s_r.release_current_level) begin
          s_nxt.brake = 1'b1;
          tif.load = 1'b1;
          tif.load_val = s_r.release_hold_delay;
          s_nxt.st = BDP_ST_REL_HOLD;
        end
      end
      BDP_ST_REL_HOLD: begin
        if (!s_r.run_s2) begin
          s_nxt.st = BDP_ST_DECEL;
        end else if (tif.done) begin
          s_nxt.st = BDP_ST_RUN;
        end
      end
      BDP_ST_RUN: begin
        if (!s_r.run_s2) begin
          s_nxt.st = BDP_ST_DECEL;
        end else if (tif.tick && !hold_ramp) begin
          if (reaccel) begin
            s_nxt.freq = ramp_up(s_r.freq, s_r.ramp_step, s_r.target_freq);
          end else if (s_r.freq < s_r.target_freq) begin
            s_nxt.freq = ramp_up(s_r.freq, s_r.ramp_step, s_r.target_freq);
          end else if (s_r.freq > s_r.target_freq) begin
            s_nxt.freq = ramp_dn(s_r.freq, s_r.ramp_step, s_r.target_freq);
          end
        end
      end
      BDP_ST_DECEL: begin
        if (s_r.run_s2 && (s_r.brake || !bseq_en)) begin
          s_nxt.st = BDP_ST_RUN;
        end else if (s_r.run_s2) begin
          s_nxt.st = BDP_ST_TO_REL;
        end else if (s_r.freq <= floor_f) begin
          if (bseq_en) begin
            s_nxt.brake = 1'b0;
            tif.load = 1'b1;
            tif.load_val = s_r.engage_hold_delay;
            s_nxt.st = BDP_ST_ENG_HOLD;
          end else if (dcb_cfg) begin
            s_nxt.freq = '0;
            tif.load = 1'b1;
            tif.load_val = s_r.dc_brake_duration;
            s_nxt.st = BDP_ST_DC_BRAKE;
          end else begin
            s_nxt.freq = '0;
            s_nxt.st = BDP_ST_BLOCK;
          end
        end else if (tif.tick && !hold_ramp) begin
          if (reaccel) begin
            s_nxt.freq = ramp_up(s_r.freq, s_r.ramp_step, s_r.target_freq);
          end else begin
            s_nxt.freq = ramp_dn(s_r.freq, s_r.ramp_step, floor_f);
          end
        end
      end
      BDP_ST_ENG_HOLD: begin
        if (tif.done) begin
          s_nxt.freq = '0;
          if (dcb_cfg) begin
            tif.load = 1'b1;
            tif.load_val = s_r.dc_brake_duration;
            s_nxt.st = BDP_ST_DC_BRAKE;
          end else begin
            s_nxt.st = BDP_ST_BLOCK;
          end
        end
      end
      BDP_ST_DC_BRAKE: begin
        if (tif.done) begin
          s_nxt.st = BDP_ST_BLOCK;
        end
      end
      BDP_ST_BLOCK: begin
        // a fresh start needs the run command to drop first
        if (!s_r.run_s2) begin
          s_nxt.st = BDP_ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = BDP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.stop_method_select <= BDP_RST_STOP;
      s_r.stall_guard_select <= BDP_RST_STALL;
      s_r.decel_voltage_limit_select <= BDP_RST_DVL;
      s_r.control_method_select <= BDP_RST_CTL;
      s_r.relay_function_select <= BDP_RST_RELAY;
      s_r.release_current_level <= BDP_RST_REL_CUR;
      s_r.release_hold_delay <= BDP_RST_REL_DLY;
      s_r.forward_release_frequency <= BDP_RST_FWD_F;
      s_r.reverse_release_frequency <= BDP_RST_REV_F;
      s_r.engage_hold_delay <= BDP_RST_ENG_DLY;
      s_r.engage_frequency <= BDP_RST_ENG_F;
      s_r.dc_brake_duration <= BDP_RST_DCB_DUR;
      s_r.dc_brake_level <= BDP_RST_DCB_LVL;
      s_r.target_freq <= BDP_RST_TGT_F;
      s_r.ramp_step <= BDP_RST_STEP;
      s_r.st <= BDP_ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign out_freq = s_r.freq;
  assign brake_release = s_r.brake;
  assign stall_active = s_r.stall;
  assign power_brake_active = s_r.pbrake;
  assign decel_vlimit_en = dvl_vis;
  assign dc_brake_on = (s_r.st == BDP_ST_DC_BRAKE);
  assign dc_brake_level_out = dc_brake_on ? s_r.dc_brake_level : 8'h00;
  assign output_block = (s_r.st == BDP_ST_IDLE) || (s_r.st == BDP_ST_BLOCK);

endmodule : bdp_brake_ctrl

// ==== verilog/bdp_pkg.sv ====
/*
  Package of the brake and deceleration protection block: register map,
  field layout, reset values, state codes and tick timing.
  Assumes a 200 MHz ref_clk; frequencies in 0.01 Hz, currents in 0.1 %,
  delays in 0.01 s units.
*/
package bdp_pkg;

  localparam int BDP_CLK_HZ = 200_000_000;
  localparam int BDP_TICK_MS = 10;
  localparam int BDP_TICK_CYCLES = BDP_CLK_HZ / 1000 * BDP_TICK_MS;
  localparam int BDP_DIV_W = 22;
  localparam int BDP_DLY_W = 10;
  localparam int BDP_FREQ_W = 16;
  localparam int BDP_CUR_W = 11;

  localparam logic [7:0] BDP_A_CFG = 8'h00;
  localparam logic [7:0] BDP_A_RELAY = 8'h04;
  localparam logic [7:0] BDP_A_REL_CUR = 8'h08;
  localparam logic [7:0] BDP_A_REL_DLY = 8'h0C;
  localparam logic [7:0] BDP_A_FWD_F = 8'h10;
  localparam logic [7:0] BDP_A_REV_F = 8'h14;
  localparam logic [7:0] BDP_A_ENG_DLY = 8'h18;
  localparam logic [7:0] BDP_A_ENG_F = 8'h1C;
  localparam logic [7:0] BDP_A_DCB_DUR = 8'h20;
  localparam logic [7:0] BDP_A_DCB_LVL = 8'h24;
  localparam logic [7:0] BDP_A_TGT_F = 8'h28;
  localparam logic [7:0] BDP_A_STEP = 8'h2C;
  localparam logic [7:0] BDP_A_STATUS = 8'h30;
  localparam logic [7:0] BDP_A_FREQ = 8'h34;

  // configuration word field positions
  localparam int BDP_CFG_STOP_LSB = 0;
  localparam int BDP_CFG_STALL_LSB = 2;
  localparam int BDP_CFG_DVL_BIT = 5;
  localparam int BDP_CFG_CTL_LSB = 6;
  localparam int BDP_STALL_ACC_BIT = 0;
  localparam int BDP_STALL_CON_BIT = 1;
  localparam int BDP_STALL_DEC_BIT = 2;

  localparam logic [1:0] BDP_STOP_POWER_BRAKE = 2'h3;
  localparam logic [4:0] BDP_RELAY_BRAKE = 5'h13;

  localparam logic [1:0] BDP_RST_STOP = 2'h0;
  localparam logic [2:0] BDP_RST_STALL = 3'h0;
  localparam logic BDP_RST_DVL = 1'b0;
  localparam logic [1:0] BDP_RST_CTL = 2'h0;
  localparam logic [4:0] BDP_RST_RELAY = 5'h11;
  localparam logic [10:0] BDP_RST_REL_CUR = 11'h1F4;
  localparam logic [9:0] BDP_RST_REL_DLY = 10'h064;
  localparam logic [15:0] BDP_RST_FWD_F = 16'h0064;
  localparam logic [15:0] BDP_RST_REV_F = 16'h0064;
  localparam logic [9:0] BDP_RST_ENG_DLY = 10'h064;
  localparam logic [15:0] BDP_RST_ENG_F = 16'h00C8;
  localparam logic [9:0] BDP_RST_DCB_DUR = 10'h000;
  localparam logic [7:0] BDP_RST_DCB_LVL = 8'h00;
  localparam logic [15:0] BDP_RST_TGT_F = 16'h0000;
  localparam logic [15:0] BDP_RST_STEP = 16'h0001;

  typedef enum logic [3:0] {
    BDP_ST_IDLE = 4'h0,
    BDP_ST_TO_REL = 4'h1,
    BDP_ST_WAIT_CUR = 4'h2,
    BDP_ST_REL_HOLD = 4'h3,
    BDP_ST_RUN = 4'h4,
    BDP_ST_DECEL = 4'h5,
    BDP_ST_ENG_HOLD = 4'h6,
    BDP_ST_DC_BRAKE = 4'h7,
    BDP_ST_BLOCK = 4'h8
  } bdp_state_t;

endpackage : bdp_pkg

// ==== verilog/bdp_tmr_if.sv ====
/*
  Interface between the sequencer and its hold timer: tick pulse, load
  strobe with a count in ticks, and the expiry level.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
interface bdp_tmr_if;
  import bdp_pkg::*;
  logic tick;
  logic load;
  logic [BDP_DLY_W-1:0] load_val;
  logic done;
  modport ctrl (input tick, input done, output load, output load_val);
  modport tmr (output tick, output done, input load, input load_val);
endinterface : bdp_tmr_if

// ==== verilog/bdp_hold_timer.sv ====
/*
  Hold timer: divides ref_clk to a 0.01 s tick and counts a loaded delay
  down in ticks. Assumes load is a one-cycle strobe from the sequencer.
*/
`timescale 1ns/1ps
module bdp_hold_timer
  import bdp_pkg::*;
#(
  parameter int TICK_CYCLES = BDP_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  bdp_tmr_if.tmr tif
);

  typedef struct packed {
    logic [BDP_DIV_W-1:0] div;
    logic [BDP_DLY_W-1:0] cnt;
    logic tick;
  } bdp_tmr_state_t;

  bdp_tmr_state_t s_r;
  bdp_tmr_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.div == BDP_DIV_W'(TICK_CYCLES - 1)) begin
      s_nxt.div = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 1'b1;
    end
    if (tif.load) begin
      s_nxt.cnt = tif.load_val;
    end else if (s_r.tick && s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tif.tick = s_r.tick;
  assign tif.done = (s_r.cnt == '0);

endmodule : bdp_hold_timer

// ==== sim/bdp_brake_motor.sv ====
/*
  Partner model: electromechanical brake on an induction motor shaft.
  Assumes ref_clk domain and out_freq/brake_release from the drive block.
*/
`timescale 1ns/1ps
module bdp_brake_motor
  import bdp_pkg::*;
#(
  parameter int CUR_STEP = 1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [BDP_FREQ_W-1:0] out_freq,
  input wire logic brake_release,
  output logic [BDP_CUR_W-1:0] motor_current
);
  logic [BDP_CUR_W-1:0] cur_r;
  assign motor_current = cur_r;
  // a shaft held by the brake loads up slowly; a small CUR_STEP makes a slow partner
  always_ff @(posedge ref_clk) begin
    if (srst || out_freq == 16'h0000) begin
      cur_r <= 11'h000;
    end else if (brake_release) begin
      cur_r <= 11'h12C;
    end else if (cur_r < 11'h700) begin
      cur_r <= cur_r + 11'(CUR_STEP);
    end
  end
endmodule : bdp_brake_motor

// ==== sim/bdp_brake_chk.sv ====
/*
  Checker of the brake and stall outputs of bdp_brake_ctrl.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module bdp_brake_chk
  import bdp_pkg::*;
#(
  parameter int TICK_CYCLES = BDP_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [BDP_FREQ_W-1:0] out_freq,
  input wire logic brake_release,
  input wire logic stall_active,
  input wire logic power_brake_active,
  input wire logic dc_brake_on,
  input wire logic [7:0] dc_brake_level_out,
  input wire logic output_block
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_release;
    $rose(brake_release);
  endsequence
  sequence s_engage;
    $fell(brake_release);
  endsequence
  sequence s_stalled;
    stall_active [*3];
  endsequence
  a_pb_wins_stall: assert property (power_brake_active |-> !stall_active)
    else $error("stall guard active during power braking");
  a_block_no_rel: assert property (output_block |-> !brake_release)
    else $error("brake released while output blocked");
  a_block_zero: assert property (output_block |-> out_freq == 16'h0000)
    else $error("frequency present while output blocked");
  a_dcb_level: assert property (!dc_brake_on |-> dc_brake_level_out == 8'h00)
    else $error("dc brake level outside dc braking");
  a_dcb_quiet: assert property (dc_brake_on |-> out_freq == 16'h0000 && !brake_release)
    else $error("dc braking with frequency or released brake");
  a_rel_hold: assert property (s_release |=> $stable(out_freq) [*8])
    else $error("frequency moved during release hold");
  a_eng_hold: assert property (s_engage |=> $stable(out_freq) [*8])
    else $error("frequency moved during engage hold");
  a_rel_running: assert property (s_release |-> !output_block && out_freq != 16'h0000)
    else $error("brake released at standstill");
  a_stall_pause: assert property (s_stalled |-> $stable(out_freq))
    else $error("ramp moved while stall guard active");
endmodule : bdp_brake_chk

bind bdp_brake_ctrl bdp_brake_chk #(.TICK_CYCLES(TICK_CYCLES)) i_bdp_brake_chk (.ref_clk, .srst,
  .out_freq, .brake_release, .stall_active, .power_brake_active, .dc_brake_on,
  .dc_brake_level_out, .output_block);

// ==== sim/tb.sv ====
/*
  Testbench of bdp_brake_ctrl: register map, stall guard and brake sequence.
  Assumes the brake/motor partner model and a short tick for simulation.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t got %h exp %h", $time, a, e); end end
`define RD(a, e) begin rd(a, d); `CHK(d, e) end
`define WT(c) for (k = 0; (c) !== 1'b1; k++) begin if (k > 20000) begin n_mismatch++; break; end \
  @(posedge ref_clk); #1; end
module tb;
  import bdp_pkg::*;
  logic ref_clk, srst, reg_wr, reg_rd, forward_run_command, reverse_select, dc_bus_over;
  logic [7:0] reg_addr, dc_brake_level_out;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [BDP_CUR_W-1:0] motor_current;
  logic [BDP_FREQ_W-1:0] out_freq, f0;
  logic brake_release, stall_active, power_brake_active, decel_vlimit_en, dc_brake_on;
  logic output_block;
  int n_mismatch = 0, num_checks = 0, k;

  bdp_brake_ctrl #(.TICK_CYCLES(10)) i_bdp_brake_ctrl (.ref_clk, .srst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .forward_run_command, .reverse_select, .dc_bus_over,
    .motor_current, .out_freq, .brake_release, .stall_active, .power_brake_active,
    .decel_vlimit_en, .dc_brake_on, .dc_brake_level_out, .output_block);
  bdp_brake_motor #(.CUR_STEP(1)) i_bdp_brake_motor (.ref_clk, .srst, .out_freq,
    .brake_release, .motor_current);

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic nap(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : nap

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    forward_run_command = 1'b0;
    reverse_select = 1'b0;
    dc_bus_over = 1'b0;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    `RD(8'h04, 32'h11)
    `RD(8'h08, 32'h0)
    wr(8'h0C, 32'h5);
    `RD(8'h3C, 32'h0)
    wr(8'h04, 32'h13);
    `RD(8'h0C, 32'h64)
    `RD(8'h08, 32'h1F4)
    `RD(8'h10, 32'h64)
    `RD(8'h14, 32'h64)
    `RD(8'h18, 32'h64)
    `RD(8'h1C, 32'hC8)
    wr(8'h00, 32'h20);
    `RD(8'h00, 32'h0)
    `CHK(decel_vlimit_en, 1'b0)
    wr(8'h00, 32'h30);
    `RD(8'h00, 32'h30)
    `CHK(decel_vlimit_en, 1'b1)
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, 32'(s));
      rd(8'h30, d);
      `CHK(d[2], 1'(s == 3))
    end
    $display("test registers done");
    wr(8'h00, 32'h0);
    wr(8'h0C, 32'h3);
    wr(8'h18, 32'h3);
    wr(8'h14, 32'h96);
    wr(8'h28, 32'h190);
    wr(8'h2C, 32'h32);
    wr(8'h20, 32'h2);
    wr(8'h24, 32'h40);
    for (int r = 0; r < 2; r++) begin
      @(posedge ref_clk) reverse_select <= 1'(r);
      @(posedge ref_clk) forward_run_command <= 1'b1;
      `WT(out_freq == (r ? 16'h0096 : 16'h0064))
      `CHK(brake_release, 1'b0)
      `WT(brake_release)
      `CHK(out_freq, r ? 16'h0096 : 16'h0064)
      `CHK(motor_current >= 11'h1F4, 1'b1)
      // the release hold is at least two whole ticks, so 20 cycles on the frequency must not move
      nap(20);
      `CHK(out_freq, r ? 16'h0096 : 16'h0064)
      `WT(out_freq == 16'h0190)
      `CHK(brake_release, 1'b1)
      @(posedge ref_clk) forward_run_command <= 1'b0;
      `WT(!brake_release)
      `CHK(out_freq, 16'h00C8)
      nap(15);
      `CHK(out_freq, 16'h00C8)
      `WT(dc_brake_on)
      `CHK(dc_brake_level_out, 8'h40)
      `CHK(out_freq, 16'h0000)
      `WT(output_block)
      `CHK(dc_brake_on, 1'b0)
      $display("test brake sequence done");
    end
    wr(8'h04, 32'h11);
    wr(8'h2C, 32'h1);
    wr(8'h00, 32'h04);
    @(posedge ref_clk) forward_run_command <= 1'b1;
    nap(40);
    // with a step of one, the ramp moves exactly once every tick of 10 cycles
    f0 = out_freq;
    `WT(out_freq !== f0)
    f0 = out_freq;
    nap(9);
    `CHK(out_freq, f0)
    nap(1);
    `CHK(out_freq, f0 + 16'h0001)
    @(posedge ref_clk) dc_bus_over <= 1'b1;
    nap(20);
    `CHK(stall_active, 1'b1)
    f0 = out_freq;
    nap(40);
    `CHK(out_freq, f0)
    wr(8'h00, 32'h18);
    nap(20);
    `CHK(stall_active, 1'b0)
    @(posedge ref_clk) dc_bus_over <= 1'b0;
    `WT(out_freq == 16'h0190)
    wr(8'h00, 32'h08);
    @(posedge ref_clk) dc_bus_over <= 1'b1;
    nap(20);
    `CHK(stall_active, 1'b1)
    wr(8'h00, 32'h14);
    nap(20);
    `CHK(stall_active, 1'b0)
    @(posedge ref_clk) dc_bus_over <= 1'b0;
    @(posedge ref_clk) forward_run_command <= 1'b0;
    nap(200);
    wr(8'h00, 32'h10);
    @(posedge ref_clk) dc_bus_over <= 1'b1;
    nap(20);
    `CHK(stall_active, 1'b1)
    wr(8'h00, 32'h13);
    nap(20);
    `CHK(stall_active, 1'b0)
    `CHK(power_brake_active, 1'b1)
    f0 = out_freq;
    nap(40);
    `CHK(out_freq > f0, 1'b1)
    @(posedge ref_clk) dc_bus_over <= 1'b0;
    `WT(output_block)
    $display("test stall guard done");
    wrap_up();
  end
endmodule : tb
